// [phio_top.sv]
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// parallel handshake port: apb registers and handshake control
// ------------------------------------------------------------------
module phio_top #(
  parameter int PULSE_CYC = phio_pkg::PHIO_STROBE_OUT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // strobes
  input  wire logic        strobe_in,
  output logic             strobe_out,
  // port c pins
  input  wire logic [7:0]  portc_in,
  output logic      [7:0]  portc_out,
  output logic      [7:0]  portc_oe,
  // port b pins
  output logic      [7:0]  portb_out,
  // interrupt request
  output logic             irq_req
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  phio_pkg::phio_ctrl_t ctrl_reg;
  phio_pkg::phio_mode_t mode;

  logic        strobe_in_flag_reg;
  logic        armed_reg;
  logic [7:0]  portc_latch_reg;
  logic [7:0]  portc_data_reg;
  logic [7:0]  portc_direction_reg;
  logic [7:0]  portb_data_reg;

  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        strobe_out_reg;
  logic [7:0]  portc_out_reg;
  logic [7:0]  portc_oe_reg;
  logic        irq_reg;

  logic        edge_hit;
  logic        sr_q;
  logic        sr_set;
  logic        sr_clr;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // direction bit only counts in full handshake
  always_comb begin
    if (!ctrl_reg.full_hs) begin
      mode = phio_pkg::PHIO_SIMPLE;
    end else if (ctrl_reg.out_dir) begin
      mode = phio_pkg::PHIO_FULL_OUT;                // see R12
    end else begin
      mode = phio_pkg::PHIO_FULL_IN;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic byte0_en;
  logic addr_ok;

  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable & pready_reg;
  assign wr_done  = acc_done & pwrite & ~pslverr_reg;
  assign rd_done  = acc_done & ~pwrite & ~pslverr_reg;
  assign byte0_en = pstrb[0];

  // only the six words below answer without error
  always_comb begin
    unique case (paddr)
      phio_pkg::PHIO_CTRL_OFS,
      phio_pkg::PHIO_LATCH_OFS,
      phio_pkg::PHIO_PORTB_OFS,
      phio_pkg::PHIO_PORTC_OFS,
      phio_pkg::PHIO_DIR_OFS,
      phio_pkg::PHIO_PINS_OFS: addr_ok = 1'b1;
      default:                 addr_ok = 1'b0;
    endcase
  end

  logic wr_ctrl;
  logic wr_latch;
  logic wr_portb;
  logic wr_portc;
  logic wr_dir;
  logic rd_ctrl;
  logic rd_latch;

  assign wr_ctrl  = wr_done & byte0_en & (paddr == phio_pkg::PHIO_CTRL_OFS);
  assign wr_latch = wr_done & byte0_en & (paddr == phio_pkg::PHIO_LATCH_OFS);
  assign wr_portb = wr_done & byte0_en & (paddr == phio_pkg::PHIO_PORTB_OFS);
  assign wr_portc = wr_done & byte0_en & (paddr == phio_pkg::PHIO_PORTC_OFS);
  assign wr_dir   = wr_done & byte0_en & (paddr == phio_pkg::PHIO_DIR_OFS);
  assign rd_ctrl  = rd_done & (paddr == phio_pkg::PHIO_CTRL_OFS);
  assign rd_latch = rd_done & (paddr == phio_pkg::PHIO_LATCH_OFS);

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // one wait-free access phase; pready rises for exactly one cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~addr_ok;
    end
  end

  // read data is sampled in the setup cycle, flag included
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr)
      phio_pkg::PHIO_CTRL_OFS: begin
        rd_byte                         = {1'b0, ctrl_reg};
        rd_byte[phio_pkg::PHIO_FLAG_BIT] = strobe_in_flag_reg;
      end
      phio_pkg::PHIO_LATCH_OFS: rd_byte = portc_latch_reg;
      phio_pkg::PHIO_PORTB_OFS: rd_byte = portb_data_reg;
      phio_pkg::PHIO_PORTC_OFS: rd_byte = portc_data_reg;
      phio_pkg::PHIO_DIR_OFS:   rd_byte = portc_direction_reg;
      phio_pkg::PHIO_PINS_OFS:  rd_byte = portc_in;
      default:                  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // reset forces simple strobe mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= phio_pkg::PHIO_CTRL_RST[6:0];     // see R22
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[6:0];                      // polarity flips pin only, see R17
    end
  end

  // ----------------------------------------------------------------
  // port data registers
  // ----------------------------------------------------------------
  // port b is always a plain output; strobe tie-in is mode gated
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portb_data_reg <= phio_pkg::PHIO_DATA_RST;
    end else if (wr_portb) begin
      portb_data_reg <= pwdata[7:0];                // see R11
    end
  end

  // in output handshake a latch write places output data, as a port write does
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portc_data_reg <= phio_pkg::PHIO_DATA_RST;
    end else if (wr_latch && mode == phio_pkg::PHIO_FULL_OUT) begin
      portc_data_reg <= pwdata[7:0];                // see R21
    end else if (wr_portc) begin
      portc_data_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portc_direction_reg <= phio_pkg::PHIO_DATA_RST;
    end else if (wr_dir) begin
      portc_direction_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // strobe_in edge and input latch
  // ----------------------------------------------------------------
  phio_edge_det u_edge (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .strobe_in (strobe_in),
    .edge_sel  (ctrl_reg.edge_sel),
    .edge_hit  (edge_hit)
  );

  // latch in every mode; pins are sampled on the edge cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portc_latch_reg <= phio_pkg::PHIO_DATA_RST;
    end else if (edge_hit) begin
      portc_latch_reg <= portc_in;                  // see R1
    end
  end

  // ----------------------------------------------------------------
  // strobe_in flag and two step clear
  // ----------------------------------------------------------------
  // completing access is judged with the mode of this cycle
  logic clear_step;

  assign clear_step = (mode == phio_pkg::PHIO_FULL_OUT) ? wr_latch  // see R4
                                                        : rd_latch; // see R5

  // arm on control read with flag set; a selected strobe_in edge disarms
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else if (edge_hit) begin
      armed_reg <= 1'b0;                            // see R6
    end else if (rd_ctrl && strobe_in_flag_reg) begin
      armed_reg <= 1'b1;                            // see R3
    end else if (clear_step) begin
      armed_reg <= 1'b0;
    end
  end

  // set wins over the clear; flag moves only on a clock edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strobe_in_flag_reg <= 1'b0;
    end else if (edge_hit) begin
      strobe_in_flag_reg <= 1'b1;                   // see R2
    end else if (armed_reg && clear_step) begin
      strobe_in_flag_reg <= 1'b0;                   // see R3
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // level request, masked by the enable bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= strobe_in_flag_reg & ctrl_reg.irq_en;  // see R7
    end
  end

  // ----------------------------------------------------------------
  // strobe_out generation
  // ----------------------------------------------------------------
  // set source depends on mode; port b writes only in simple mode
  always_comb begin
    unique case (mode)
      phio_pkg::PHIO_SIMPLE:   sr_set = wr_portb;   // see R10
      phio_pkg::PHIO_FULL_IN:  sr_set = rd_latch;   // see R18
      phio_pkg::PHIO_FULL_OUT: sr_set = wr_latch;   // see R21
    endcase
  end

  // in full handshake an edge negates the strobe; a set in the same cycle wins
  assign sr_clr = ctrl_reg.full_hs & edge_hit;      // see R19

  logic interlock;

  // simple mode is always pulsed
  assign interlock = ctrl_reg.full_hs & ~ctrl_reg.pulse;  // see R14

  phio_strobe_gen #(
    .PULSE_CYC (PULSE_CYC)
  ) u_strobe_out (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .set_req   (sr_set),
    .ack_clr   (sr_clr),
    .interlock (interlock),
    .q         (sr_q)
  );

  // polarity is applied after the flop, so toggling it keeps state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strobe_out_reg <= ~phio_pkg::PHIO_CTRL_RST[phio_pkg::PHIO_POL_BIT];
    end else begin
      strobe_out_reg <= ctrl_reg.active_high ? sr_q : ~sr_q;  // see R17
    end
  end

  // ----------------------------------------------------------------
  // port c drivers
  // ----------------------------------------------------------------
  // three-state variant: in output handshake an active strobe_in level drives all pins not held off by open drain
  logic       ts_en;
  logic [7:0] drive_en;
  logic [7:0] oe_next;

  assign ts_en    = (mode == phio_pkg::PHIO_FULL_OUT)
                    & (ctrl_reg.edge_sel ^ strobe_in);  // see R16
  assign drive_en = portc_direction_reg | {8{ts_en}};

  // open drain: only drive low; external pull-up gives the high
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign oe_next[gi] = drive_en[gi]
                           & ~(ctrl_reg.open_drain & portc_data_reg[gi]);  // see R9
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portc_oe_reg  <= 8'h00;
      portc_out_reg <= phio_pkg::PHIO_DATA_RST;
    end else begin
      portc_oe_reg  <= oe_next;
      portc_out_reg <= portc_data_reg;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign strobe_out = strobe_out_reg;
  assign portc_out  = portc_out_reg;
  assign portc_oe   = portc_oe_reg;
  assign portb_out  = portb_data_reg;
  assign irq_req    = irq_reg;                      // see R8

endmodule : phio_top

// [phio_pkg.sv]
// Notes on behaviour
// R1 - selected strobe_in edge latches port C, sets flag
// R2 - flag sets on a clock edge, synchronously
// R3 - flag clear: control read arms, access completes
// R4 - completing access: latch read, or write in output
// R5 - completing access judged by mode at that time
// R6 - strobe_in edge disarms; pending clear is dropped
// R7 - irq raised while flag set and enable high
// R8 - irq is one maskable request line
// R9 - open drain: port C never drives high
// R10 - simple mode: port B write pulses strobe_out
// R11 - full handshake: port B is plain output
// R12 - direction bit matters only in full handshake
// R13 - interlocked strobe_out holds until strobe_in edge
// R14 - pulse lasts two E cycles; simple always pulsed
// R15 - edge select: 0 falling, 1 rising
// R16 - three-state output enable is edge_sel xor strobe_in
// R17 - one set/reset flop, polarity select outside it
// R18 - input handshake: latch read asserts strobe_out
// R19 - input handshake: strobe_in edge negates strobe_out
// R20 - partner waits for ready before new strobe
// R21 - output handshake: latch write drives, asserts strobe
// R22 - reset selects simple strobe mode
package phio_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PHIO_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PHIO_LATCH_OFS  = 8'h04;
  localparam logic [7:0] PHIO_PORTB_OFS  = 8'h08;
  localparam logic [7:0] PHIO_PORTC_OFS  = 8'h0C;
  localparam logic [7:0] PHIO_DIR_OFS    = 8'h10;
  localparam logic [7:0] PHIO_PINS_OFS   = 8'h14;

  // control register field positions
  localparam int PHIO_FLAG_BIT  = 7;
  localparam int PHIO_IRQEN_BIT = 6;
  localparam int PHIO_ODRN_BIT  = 5;
  localparam int PHIO_FULL_BIT  = 4;
  localparam int PHIO_OUTD_BIT  = 3;
  localparam int PHIO_PULSE_BIT = 2;
  localparam int PHIO_EDGE_BIT  = 1;
  localparam int PHIO_POL_BIT   = 0;

  // reset values
  localparam logic [7:0] PHIO_CTRL_RST  = 8'h03;
  localparam logic [7:0] PHIO_DATA_RST  = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PHIO_CLK_NS      = 4;
  localparam int PHIO_E_NS        = 500;
  localparam int PHIO_STROBE_OUT_E      = 2;
  localparam int PHIO_STROBE_OUT_CYC    = (PHIO_STROBE_OUT_E * PHIO_E_NS + PHIO_CLK_NS - 1) / PHIO_CLK_NS;

  // control fields as software writes them
  typedef struct packed {
    logic irq_en;
    logic open_drain;
    logic full_hs;
    logic out_dir;
    logic pulse;
    logic edge_sel;
    logic active_high;
  } phio_ctrl_t;

  typedef enum logic [1:0] {
    PHIO_SIMPLE,
    PHIO_FULL_IN,
    PHIO_FULL_OUT
  } phio_mode_t;

endpackage : phio_pkg

// [phio_edge_det.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// strobe_in edge detector
// ------------------------------------------------------------------
module phio_edge_det (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic strobe_in,
  input  wire logic edge_sel,
  output logic      edge_hit
);

  logic prev_reg;
  logic prime_reg;

  // previous level; first cycle after reset never reports an edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_reg  <= 1'b0;
      prime_reg <= 1'b0;
    end else begin
      prev_reg  <= strobe_in;
      prime_reg <= 1'b1;
    end
  end

  // only the selected direction counts
  assign edge_hit = prime_reg & (edge_sel ? (strobe_in & ~prev_reg)  // see R15
                                          : (~strobe_in & prev_reg));

endmodule : phio_edge_det

// [phio_strobe_gen.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// strobe_out set/reset flop with pulse timer
// ------------------------------------------------------------------
module phio_strobe_gen #(
  parameter int PULSE_CYC = phio_pkg::PHIO_STROBE_OUT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic set_req,
  input  wire logic ack_clr,
  input  wire logic interlock,
  output logic      q
);

  localparam int CW = $clog2(PULSE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(PULSE_CYC - 1);

  logic [CW-1:0] cnt_reg;
  logic          q_reg;

  // set wins over every clear so a request is never lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q_reg   <= 1'b0;
      cnt_reg <= '0;
    end else if (set_req) begin
      q_reg   <= 1'b1;                              // see R17
      cnt_reg <= '0;
    end else if (q_reg && ack_clr) begin
      q_reg   <= 1'b0;                              // see R13
    end else if (q_reg && !interlock) begin
      if (cnt_reg == LAST) begin
        q_reg <= 1'b0;                              // see R14
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign q = q_reg;

endmodule : phio_strobe_gen

// [phio_partner.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// far-side system: strobes a byte into port c on command
// ------------------------------------------------------------------
module phio_partner (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       fire,
  input  wire logic       wait_rdy,
  input  wire logic [7:0] data,
  input  wire logic       strobe_out,
  output logic            strobe_in,
  output logic      [7:0] portc_in,
  output logic            busy
);
  logic [3:0] cnt_reg;

  // strobe three cycles high, data held five cycles past the fall
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else if (fire && (!wait_rdy || strobe_out)) begin
      cnt_reg <= 4'h8;
    end
  end

  // idle bus shows the inverse, so a late latch sample is caught
  assign strobe_in = (cnt_reg > 4'h5);
  assign portc_in  = (cnt_reg != 4'h0) ? data : ~data;
  assign busy      = (cnt_reg != 4'h0);
endmodule : phio_partner

// [phio_top_properties.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// port-level checks for the handshake port
// ------------------------------------------------------------------
module phio_top_properties #(
  parameter int PULSE_CYC = phio_pkg::PHIO_STROBE_OUT_CYC
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        strobe_in,
  input wire logic        strobe_out,
  input wire logic [7:0]  portc_out,
  input wire logic [7:0]  portc_oe,
  input wire logic [7:0]  portb_out,
  input wire logic        irq_req
);
  logic [7:0]  ctrl_reg;
  logic [15:0] run_reg;
  logic [3:0]  hist_reg;
  wire         wr_acc = psel && penable && pready && pwrite && pstrb[0];
  wire         full_w = ctrl_reg[phio_pkg::PHIO_FULL_BIT];
  wire         outd_w = ctrl_reg[phio_pkg::PHIO_OUTD_BIT];
  wire         puls_w = ctrl_reg[phio_pkg::PHIO_PULSE_BIT];
  wire         edge_w = ctrl_reg[phio_pkg::PHIO_EDGE_BIT];
  wire         pol_w  = ctrl_reg[phio_pkg::PHIO_POL_BIT];
  wire         odrn_w = ctrl_reg[phio_pkg::PHIO_ODRN_BIT];
  wire         irqe_w = ctrl_reg[phio_pkg::PHIO_IRQEN_BIT];
  wire         hit_w  = edge_w ? |(hist_reg[2:0] & ~hist_reg[3:1])
                               : |(~hist_reg[2:0] & hist_reg[3:1]);

  // shadow of the control fields, history of strobe_in, run of strobe_out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= phio_pkg::PHIO_CTRL_RST;
    end else if (wr_acc && paddr == phio_pkg::PHIO_CTRL_OFS) begin
      ctrl_reg <= pwdata[7:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    hist_reg <= {hist_reg[2:0], strobe_in};
    run_reg  <= strobe_out ? run_reg + 16'h0001 : 16'h0000;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence portb_wr_s;
    wr_acc && paddr == phio_pkg::PHIO_PORTB_OFS && !full_w && pol_w;
  endsequence
  sequence oe_active_s;
    (full_w && outd_w && !odrn_w && (edge_w ^ strobe_in)) [*3];
  endsequence

  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  portb_strobe_a: assert property (portb_wr_s |-> ##[1:3] strobe_out)
    else $error("no strobe after port b write");
  portb_source_a: assert property ($changed(portb_out) |->
    $past(wr_acc && paddr == phio_pkg::PHIO_PORTB_OFS))
    else $error("port b changed without a write");
  pulse_length_a: assert property ($fell(strobe_out) && pol_w &&
    (!full_w || puls_w) |-> run_reg == 16'(PULSE_CYC))
    else $error("strobe pulse of wrong length");
  interlock_hold_a: assert property ($fell(strobe_out) && full_w &&
    !puls_w && pol_w && $past(pol_w) |-> hit_w)
    else $error("interlocked strobe dropped without edge");
  threestate_oe_a: assert property (oe_active_s |-> portc_oe == 8'hFF)
    else $error("port c not driven while strobe active");
  open_drain_a: assert property (odrn_w && $past(odrn_w, 2) &&
    $stable(portc_out) |-> (portc_oe & portc_out) == 8'h00)
    else $error("open drain pin driven high");
  irq_mask_a: assert property (!irqe_w && $past(!irqe_w) |-> !irq_req)
    else $error("interrupt while disabled");
  irq_fall_a: assert property ($fell(irq_req) |->
    $past(pready) || $past(pready, 2) || $past(pready, 3))
    else $error("interrupt dropped without access");
endmodule : phio_top_properties

bind phio_top phio_top_properties #(.PULSE_CYC(PULSE_CYC)) u_phio_top_properties (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .strobe_in(strobe_in),
  .strobe_out(strobe_out), .portc_out(portc_out), .portc_oe(portc_oe),
  .portb_out(portb_out), .irq_req(irq_req));

// [phio_top_bench.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// self-checking bench for the handshake port
// ------------------------------------------------------------------
module phio_top_bench;
  localparam int PULSE = 4;
  logic        clk_sys  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h00000000;
  logic [3:0]  pstrb    = 4'hF;
  logic        fire     = 1'b0;
  logic        wait_rdy = 1'b0;
  logic [7:0]  pdata    = 8'h00;
  logic [31:0] prdata;
  logic        pready, pslverr, strobe_in, strobe_out, irq_req, pbusy, rerr;
  logic [7:0]  portc_in, portc_out, portc_oe, portb_out, rdata, len;
  int          err_count = 0;
  int          checks    = 0;

  // 250 MHz system clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  phio_top #(.PULSE_CYC(PULSE)) u_phio_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strobe_in(strobe_in), .strobe_out(strobe_out),
    .portc_in(portc_in), .portc_out(portc_out), .portc_oe(portc_oe),
    .portb_out(portb_out), .irq_req(irq_req));
  phio_partner u_phio_partner (
    .clk_sys(clk_sys), .rst_n(rst_n), .fire(fire), .wait_rdy(wait_rdy), .data(pdata),
    .strobe_out(strobe_out), .strobe_in(strobe_in), .portc_in(portc_in), .busy(pbusy));

  task automatic conclude();
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic limit(input int n, input int max);
    if (n >= max) begin
      err_count++;
      conclude();
    end
  endtask : limit

  function automatic logic pick(input int k);
    case (k)
      1: return pbusy;
      default: return strobe_out;
    endcase
  endfunction : pick

  // sampled on falling edges so registered outputs have settled
  task automatic await(input int k, input logic lvl, input int max, output int n);
    n = 0;
    @(negedge clk_sys);
    while (pick(k) !== lvl && n < max) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : await

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    limit(n, 50);
    rdata = prdata[7:0];
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rdata, e);
  endtask : rc

  task automatic rcc(input logic [7:0] e);
    rc(phio_pkg::PHIO_CTRL_OFS, e);
  endtask : rcc

  task automatic rcl(input logic [7:0] e);
    rc(phio_pkg::PHIO_LATCH_OFS, e);
  endtask : rcl

  task automatic wc(input logic [7:0] d);
    apb(1'b1, phio_pkg::PHIO_CTRL_OFS, d);
  endtask : wc

  // commands one strobe from the far side and lets the flag settle
  task automatic strobe(input logic [7:0] d, input logic w);
    int n;
    @(posedge clk_sys);
    pdata    <= d;
    wait_rdy <= w;
    fire     <= 1'b1;
    await(1, 1'b1, 50, n);
    limit(n, 50);
    @(posedge clk_sys);
    fire <= 1'b0;
    await(1, 1'b0, 50, n);
    limit(n, 50);
    idle(3);
  endtask : strobe

  // length of the next strobe_out pulse, zero if none comes
  task automatic pulse_len(output logic [7:0] l);
    int n;
    await(2, 1'b1, 30, n);
    l = 8'h00;
    if (strobe_out === 1'b1) begin
      await(2, 1'b0, 300, n);
      l = 8'(n + 1);
    end
  endtask : pulse_len

  // main sequence: reset, then one scenario after another
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rcc(8'h03);
    apb(1'b0, 8'h18, 8'h00);
    check({7'h00, rerr}, 8'h01);
    wc(8'h83);
    rcc(8'h03);
    apb(1'b1, phio_pkg::PHIO_PORTB_OFS, 8'h5A);
    pulse_len(len);
    check(len, 8'(PULSE));
    wc(8'h43);
    strobe(8'h5A, 1'b0);
    check({7'h00, irq_req}, 8'h01);
    wc(8'h03);
    idle(3);
    check({7'h00, irq_req}, 8'h00);
    wc(8'h43);
    idle(3);
    check({7'h00, irq_req}, 8'h01);
    rcc(8'hC3);
    rcl(8'h5A);
    idle(3);
    check({7'h00, irq_req}, 8'h00);
    wc(8'h03);
    strobe(8'h11, 1'b0);
    rcc(8'h83);
    strobe(8'h22, 1'b0);
    rcl(8'h22);
    rcc(8'h83);
    rcl(8'h22);
    rcc(8'h03);
    // armed in simple mode, completed by a latch write in output mode
    strobe(8'h33, 1'b0);
    rcc(8'h83);
    wc(8'h1B);
    rcl(8'h33);
    rcc(8'h9B);
    apb(1'b1, phio_pkg::PHIO_LATCH_OFS, 8'h3C);
    rcc(8'h1B);
    idle(10);
    check({7'h00, strobe_out}, 8'h01);
    check(portc_out, 8'h3C);
    check(portc_oe, 8'hFF);
    strobe(8'h00, 1'b0);
    check({7'h00, strobe_out}, 8'h00);
    rcc(8'h9B);
    wc(8'h3B);
    idle(3);
    check(portc_oe, 8'hC3);
    // input handshake, interlocked then pulsed
    wc(8'h13);
    rcc(8'h93);
    check({7'h00, strobe_out}, 8'h00);
    rcl(8'h00);
    idle(2);
    check({7'h00, strobe_out}, 8'h01);
    rcc(8'h13);
    strobe(8'h96, 1'b1);
    check({7'h00, strobe_out}, 8'h00);
    rcc(8'h93);
    rcl(8'h96);
    wc(8'h12);
    idle(2);
    check({7'h00, strobe_out}, 8'h00);
    wc(8'h13);
    idle(2);
    check({7'h00, strobe_out}, 8'h01);
    wc(8'h11);
    strobe(8'h69, 1'b0);
    check({7'h00, strobe_out}, 8'h00);
    rcc(8'h91);
    wc(8'h17);
    rcl(8'h69);
    pulse_len(len);
    check(len, 8'(PULSE));
    apb(1'b1, phio_pkg::PHIO_PORTB_OFS, 8'h11);
    pulse_len(len);
    check(len, 8'h00);
    check(portb_out, 8'h11);
    // direction bit has no say in simple mode
    wc(8'h0B);
    strobe(8'h44, 1'b0);
    rcc(8'h8B);
    apb(1'b1, phio_pkg::PHIO_LATCH_OFS, 8'h55);
    rcc(8'h8B);
    conclude();
  end
endmodule : phio_top_bench
